// [verilog/usdr_top.sv]
// register slice of the serial port: status two, data registers, shared baud, pins
// Behaviour
// - bank select swaps registers at offsets zero-two
// - transmit polarity bit inverts outgoing line
// - receive polarity bit inverts incoming line
// - long break select makes 13/14-bit breaks
// - framing check ignores break length setting
// - single wire direction bit drives pin enable
// - receiver active sets at first start slot
// - receiver active clears on idle character
// - data low reads receive, writes transmit
// - data high holds both ninth bits
// - writes to received ninth bit ignored
// - transmit ninth bit persists across frames
// - eight-bit format needs only data low
// - test bits writable only in special mode
// - independent transmitter, receiver, one baud generator
// - character length picks eight or nine bits
`timescale 1ns/1ps
`default_nettype none
`include "usdr_defs.svh"
module usdr_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic special_mode,
    input wire logic rxd_pin,
    input wire logic txd_pin_in,
    output logic txd_pin_out,
    output logic txd_pin_oe,
    output logic irq
);
    usdr_core_if cif ();

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] baud_q;
    logic [7:0] ctrl1_q, ctrl2_q, alt_stat1_q, alt_ctrl1_q, alt_ctrl2_q;
    logic [7:0] stat1_q, stat1_d, imask_q;
    logic bank_q, txinv_q, rxinv_q, lbrk_q, dir_q;
    logic tx9_q;
    logic [2:0] test_q;
    logic [7:0] tx_data_q;
    logic tx_pend_q, brk_pend_q;
    logic [7:0] rd_data_q;
    logic [15:0] baud_cnt_q;
    logic tick_q;
    logic rxd_s1_q, rxd_s2_q, txi_s1_q, txi_s2_q;
    logic txd_out_q, txd_oe_q, irq_q;

    // ****************************************
    // address decode
    // ****************************************
    wire sel_0 = (addr == `USDR_OFS_BAUD_HI);
    wire sel_1 = (addr == `USDR_OFS_BAUD_LO);
    wire sel_2 = (addr == `USDR_OFS_CTRL1);
    wire wr_0 = wr_en && sel_0;
    wire wr_1 = wr_en && sel_1;
    wire wr_2 = wr_en && sel_2;
    wire wr_c2 = wr_en && (addr == `USDR_OFS_CTRL2);
    wire wr_s1 = wr_en && (addr == `USDR_OFS_STAT1);
    wire wr_s2 = wr_en && (addr == `USDR_OFS_STAT2);
    wire wr_dh = wr_en && (addr == `USDR_OFS_DATA_HI);
    wire wr_dl = wr_en && (addr == `USDR_OFS_DATA_LO);
    wire wr_im = wr_en && (addr == `USDR_OFS_IMASK);

    wire nine_bit = ctrl1_q[`USDR_C1_NINE];
    wire loop_mode = ctrl1_q[`USDR_C1_LOOP];
    wire single_wire = loop_mode && ctrl1_q[`USDR_C1_RSRC];
    wire tx_en = ctrl2_q[`USDR_C2_TE];
    wire rx_en = ctrl2_q[`USDR_C2_RE];

    // ****************************************
    // read mux
    // ****************************************
    wire [7:0] s2_view = {bank_q, 2'b00, txinv_q, rxinv_q, lbrk_q, dir_q, cif.rx_active};
    wire [7:0] dh_view = {cif.rx_ninth, tx9_q, 3'b000, test_q};
    wire [7:0] reg0_view = bank_q ? alt_stat1_q : baud_q[15:8];
    wire [7:0] reg1_view = bank_q ? alt_ctrl1_q : baud_q[7:0];
    wire [7:0] reg2_view = bank_q ? alt_ctrl2_q : ctrl1_q;
    wire [7:0] rd_mux =
        sel_0 ? reg0_view :
        sel_1 ? reg1_view :
        sel_2 ? reg2_view :
        (addr == `USDR_OFS_CTRL2) ? ctrl2_q :
        (addr == `USDR_OFS_STAT1) ? stat1_q :
        (addr == `USDR_OFS_STAT2) ? s2_view :
        (addr == `USDR_OFS_DATA_HI) ? dh_view :
        (addr == `USDR_OFS_DATA_LO) ? cif.rx_data :
        (addr == `USDR_OFS_IMASK) ? imask_q : 8'h00;

    // ****************************************
    // control and configuration writes
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            baud_q <= `USDR_RST_BAUD;
            ctrl1_q <= `USDR_RST_BYTE;
            ctrl2_q <= `USDR_RST_BYTE;
            alt_stat1_q <= `USDR_RST_BYTE;
            alt_ctrl1_q <= `USDR_RST_BYTE;
            alt_ctrl2_q <= `USDR_RST_BYTE;
            imask_q <= `USDR_RST_BYTE;
        end else if (ce) begin
            if (wr_0 && !bank_q) baud_q[15:8] <= wr_data;
            if (wr_1 && !bank_q) baud_q[7:0] <= wr_data;
            if (wr_2 && !bank_q) ctrl1_q <= wr_data;
            if (wr_0 && bank_q) alt_stat1_q <= wr_data;
            if (wr_1 && bank_q) alt_ctrl1_q <= wr_data;
            if (wr_2 && bank_q) alt_ctrl2_q <= wr_data;
            if (wr_c2) ctrl2_q <= wr_data;
            if (wr_im) imask_q <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bank_q <= 1'b0;
            txinv_q <= 1'b0;
            rxinv_q <= 1'b0;
            lbrk_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (ce && wr_s2) begin
            bank_q <= wr_data[`USDR_S2_BANK];
            txinv_q <= wr_data[`USDR_S2_TXINV];
            rxinv_q <= wr_data[`USDR_S2_RXINV];
            lbrk_q <= wr_data[`USDR_S2_LBRK];
            dir_q <= wr_data[`USDR_S2_DIR];
        end
    end

    // ****************************************
    // data registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx9_q <= 1'b0;
            test_q <= 3'h0;
            tx_data_q <= `USDR_RST_BYTE;
            tx_pend_q <= 1'b0;
            brk_pend_q <= 1'b0;
        end else if (ce) begin
            if (wr_dh) begin
                tx9_q <= wr_data[`USDR_DH_TX9];
                if (special_mode) test_q <= wr_data[`USDR_DH_TEST_W-1:0];
            end
            if (wr_dl) tx_data_q <= wr_data;
            tx_pend_q <= wr_dl ? 1'b1 : (tx_pend_q && !cif.tx_start);
            brk_pend_q <= (wr_c2 && wr_data[`USDR_C2_BRK]) ? 1'b1 : (brk_pend_q && !cif.tx_brk);
        end
    end

    // test bit zero holds the transmit line idle, an effect that stays after special mode ends
    wire test_hold = test_q[0];
    wire tx_free = tx_en && !cif.tx_busy && !test_hold;

    // ****************************************
    // shared baud generator and core hookup
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            baud_cnt_q <= 16'h0001;
            tick_q <= 1'b0;
        end else if (ce) begin
            tick_q <= (baud_q != 16'h0000) && (baud_cnt_q >= baud_q);
            baud_cnt_q <= (baud_cnt_q >= baud_q) ? 16'h0001 : baud_cnt_q + 16'h0001;
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            txi_s1_q <= 1'b1;
            txi_s2_q <= 1'b1;
        end else if (ce) begin
            rxd_s1_q <= rxd_pin;
            rxd_s2_q <= rxd_s1_q;
            txi_s1_q <= txd_pin_in;
            txi_s2_q <= txi_s1_q;
        end
    end

    wire line_out = cif.tx_line ^ txinv_q;
    wire rx_src = single_wire ? txi_s2_q : (loop_mode ? line_out : rxd_s2_q);
    wire rx_level = rx_en ? (rx_src ^ rxinv_q) : 1'b1;
    wire pin_oe = single_wire ? dir_q : 1'b1;

    assign cif.ce = ce;
    assign cif.tick16 = tick_q;
    assign cif.nine_bit = nine_bit;
    assign cif.tx_start = tx_free && tx_pend_q && !brk_pend_q;
    assign cif.tx_brk = tx_free && brk_pend_q;
    assign cif.long_brk = lbrk_q;
    assign cif.tx_data = tx_data_q;
    assign cif.tx_ninth = tx9_q;
    assign cif.rx_line = rx_level;

    usdr_tx u_tx (
        .clock(clock),
        .rst_b(rst_b),
        .cif(cif)
    );

    usdr_rx u_rx (
        .clock(clock),
        .rst_b(rst_b),
        .cif(cif)
    );

    // ****************************************
    // events and interrupt
    // ****************************************
    wire [7:0] ev_set = {cif.tx_done, 1'b0, cif.rx_done, cif.rx_idle, 2'b00, cif.rx_ferr, 1'b0};
    wire [7:0] ev_mask = (8'h01 << `USDR_EV_TXDONE) | (8'h01 << `USDR_EV_RXFULL)
                       | (8'h01 << `USDR_EV_IDLE) | (8'h01 << `USDR_EV_FERR);
    // set wins over a same-cycle clear
    assign stat1_d = ((stat1_q & ~(wr_s1 ? wr_data : 8'h00)) | ev_set) & ev_mask;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stat1_q <= `USDR_RST_BYTE;
            irq_q <= 1'b0;
            rd_data_q <= `USDR_RST_BYTE;
            txd_out_q <= 1'b1;
            txd_oe_q <= 1'b1;
        end else if (ce) begin
            stat1_q <= stat1_d;
            irq_q <= |(stat1_d & imask_q);
            rd_data_q <= rd_en ? rd_mux : 8'h00;
            txd_out_q <= line_out;
            txd_oe_q <= pin_oe;
        end
    end

    assign rd_data = rd_data_q;
    assign txd_pin_out = txd_out_q;
    assign txd_pin_oe = txd_oe_q;
    assign irq = irq_q;

    // ****************************************
    // assertions
    // ****************************************
    a_bank_alt_read: assert property (@(posedge clock) disable iff (!rst_b)
        ce && rd_en && sel_1 && bank_q |=> rd_data == $past(alt_ctrl1_q))
        else $error("bank one read did not return alternate register");

    a_bank_baud_safe: assert property (@(posedge clock) disable iff (!rst_b)
        ce && wr_0 && bank_q |=> baud_q[15:8] == $past(baud_q[15:8]))
        else $error("baud divisor changed through alternate bank");

    a_tx_pol_pin: assert property (@(posedge clock) disable iff (!rst_b)
        ce && !cif.tx_busy |=> txd_pin_out == !$past(txinv_q))
        else $error("idle transmit pin level wrong for polarity");

    a_rx_pol_line: assert property (@(posedge clock) disable iff (!rst_b)
        rx_en && !loop_mode |-> cif.rx_line == (rxd_s2_q ^ rxinv_q))
        else $error("receive line not inverted per polarity");

    a_single_dir: assert property (@(posedge clock) disable iff (!rst_b)
        ce && single_wire && !dir_q |=> !txd_pin_oe)
        else $error("pin driven while configured as input");

    a_raf_sets: assert property (@(posedge clock) disable iff (!rst_b)
        ce && cif.tick16 && !cif.rx_active && !cif.rx_line && u_rx.st_q == usdr_pkg::usdr_rx_idle
        |=> cif.rx_active)
        else $error("receiver active not set at first slot");

    a_raf_clears: assert property (@(posedge clock) disable iff (!rst_b)
        ce && cif.rx_idle |-> !cif.rx_active)
        else $error("receiver active still set after idle");

    a_data_read: assert property (@(posedge clock) disable iff (!rst_b)
        rd_en && addr == `USDR_OFS_DATA_LO && ce |=> rd_data == $past(cif.rx_data))
        else $error("data low read returned wrong byte");

    a_rx9_no_write: assert property (@(posedge clock) disable iff (!rst_b)
        ce && wr_dh && !u_rx.stop_now |=> $stable(cif.rx_ninth))
        else $error("received ninth bit changed by write");

    a_tx9_keeps: assert property (@(posedge clock) disable iff (!rst_b)
        ce && cif.tx_done && !wr_dh |=> $stable(tx9_q))
        else $error("transmit ninth bit lost after frame");

    a_test_locked: assert property (@(posedge clock) disable iff (!rst_b)
        ce && wr_dh && !special_mode |=> $stable(test_q))
        else $error("test bits written outside special mode");

    a_s2_spare_zero: assert property (@(posedge clock) disable iff (!rst_b)
        ce && rd_en && addr == `USDR_OFS_STAT2
        |=> rd_data[6:5] == 2'b00)
        else $error("spare status bits not zero");

    a_ninth_read: assert property (@(posedge clock) disable iff (!rst_b)
        ce && rd_en && addr == `USDR_OFS_DATA_HI
        |=> rd_data[7:6] == {$past(cif.rx_ninth), $past(tx9_q)})
        else $error("ninth bits read wrong");

    a_tx_data_load: assert property (@(posedge clock) disable iff (!rst_b)
        ce && wr_dl
        |=> tx_data_q == $past(wr_data))
        else $error("transmit byte not loaded");

    a_ferr_stop: assert property (@(posedge clock) disable iff (!rst_b)
        ce && u_rx.stop_now
        |=> cif.rx_ferr == !$past(cif.rx_line))
        else $error("framing check wrong at stop");

    a_eight_no_ninth: assert property (@(posedge clock) disable iff (!rst_b)
        ce && u_rx.stop_now && !nine_bit
        |=> !cif.rx_ninth)
        else $error("ninth bit set in eight-bit format");

    a_pin_oe_plain: assert property (@(posedge clock) disable iff (!rst_b)
        ce && !single_wire
        |=> txd_pin_oe)
        else $error("pin released outside single wire");

    a_ninth_launch: assert property (@(posedge clock) disable iff (!rst_b)
        ce && cif.tx_start && nine_bit
        |=> u_tx.sh_q[9] == $past(tx9_q))
        else $error("ninth bit not framed");

    // ****************************************
    // cover points
    // ****************************************
    c_frame_rx: cover property (@(posedge clock) disable iff (!rst_b) cif.rx_done && !cif.rx_ferr);
    c_break_tx: cover property (@(posedge clock) disable iff (!rst_b) cif.tx_brk ##[1:1000] cif.tx_done);
    c_idle_seen: cover property (@(posedge clock) disable iff (!rst_b) cif.rx_active ##1 cif.rx_idle);
    c_irq_up: cover property (@(posedge clock) disable iff (!rst_b) $rose(irq));
    c_long_break: cover property (@(posedge clock) disable iff (!rst_b) cif.tx_brk && lbrk_q);
endmodule : usdr_top
`default_nettype wire

// [verilog/usdr_defs.svh]
// constants for the serial port register slice
`ifndef USDR_DEFS_SVH
`define USDR_DEFS_SVH

// register offsets
`define USDR_OFS_BAUD_HI 4'h0
`define USDR_OFS_BAUD_LO 4'h1
`define USDR_OFS_CTRL1 4'h2
`define USDR_OFS_CTRL2 4'h3
`define USDR_OFS_STAT1 4'h4
`define USDR_OFS_STAT2 4'h5
`define USDR_OFS_DATA_HI 4'h6
`define USDR_OFS_DATA_LO 4'h7
`define USDR_OFS_IMASK 4'h8

// status_two_control fields
`define USDR_S2_BANK 7
`define USDR_S2_TXINV 4
`define USDR_S2_RXINV 3
`define USDR_S2_LBRK 2
`define USDR_S2_DIR 1
`define USDR_S2_RAF 0

// data_high_ninth_bits fields
`define USDR_DH_RX9 7
`define USDR_DH_TX9 6
`define USDR_DH_TEST_W 3

// control_one fields
`define USDR_C1_LOOP 7
`define USDR_C1_RSRC 5
`define USDR_C1_NINE 4

// control_two fields
`define USDR_C2_TE 3
`define USDR_C2_RE 2
`define USDR_C2_BRK 0

// status_one event bits (sticky, write one to clear)
`define USDR_EV_TXDONE 7
`define USDR_EV_RXFULL 5
`define USDR_EV_IDLE 4
`define USDR_EV_FERR 1

// reset values
`define USDR_RST_BYTE 8'h00
`define USDR_RST_BAUD 16'h0004

// bit timing: sub-bit slots and idle lengths in 16x ticks, frame, data and break lengths in bits
`define USDR_SUB_LAST 4'hf
`define USDR_SUB_MID 4'h7
`define USDR_FRAME8 4'ha
`define USDR_FRAME9 4'hb
`define USDR_DATA8 4'h8
`define USDR_DATA9 4'h9
`define USDR_BRK_SHORT 4'ha
`define USDR_BRK_LONG 4'hd
`define USDR_IDLE8 8'ha0
`define USDR_IDLE9 8'hb0

`endif

// [verilog/usdr_pkg.sv]
// types shared by the serial port register slice
`default_nettype none
package usdr_pkg;
    typedef enum logic [0:0] {
        usdr_tx_idle = 1'b0,
        usdr_tx_busy = 1'b1
    } usdr_tx_state_t;
    typedef enum logic [1:0] {
        usdr_rx_idle = 2'b00,
        usdr_rx_start = 2'b01,
        usdr_rx_data = 2'b10,
        usdr_rx_stop = 2'b11
    } usdr_rx_state_t;
endpackage : usdr_pkg
`default_nettype wire

// [verilog/usdr_core_if.sv]
// signals between the register slice and its transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
interface usdr_core_if;
    logic ce;
    logic tick16;
    logic nine_bit;
    logic tx_start;
    logic tx_brk;
    logic long_brk;
    logic [7:0] tx_data;
    logic tx_ninth;
    logic tx_busy;
    logic tx_done;
    logic tx_line;
    logic rx_line;
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic rx_ferr;
    logic rx_idle;
    logic rx_active;
    modport ctrl (output ce, tick16, nine_bit, tx_start, tx_brk, long_brk, tx_data, tx_ninth, rx_line,
                  input tx_busy, tx_done, tx_line, rx_done, rx_data, rx_ninth, rx_ferr, rx_idle, rx_active);
    modport tx (input ce, tick16, nine_bit, tx_start, tx_brk, long_brk, tx_data, tx_ninth,
                output tx_busy, tx_done, tx_line);
    modport rx (input ce, tick16, nine_bit, rx_line,
                output rx_done, rx_data, rx_ninth, rx_ferr, rx_idle, rx_active);
endinterface : usdr_core_if
`default_nettype wire

// [verilog/usdr_tx.sv]
// transmitter: frames and break characters, line level before polarity
`timescale 1ns/1ps
`default_nettype none
`include "usdr_defs.svh"
module usdr_tx (
    input wire logic clock,
    input wire logic rst_b,
    usdr_core_if.tx cif
);
    usdr_pkg::usdr_tx_state_t st_q, st_d;
    logic [10:0] sh_q, sh_d;
    logic [3:0] bits_q, bits_d;
    logic [3:0] sub_q;
    logic done_q;

    wire bit_tick = cif.tick16 && (sub_q == `USDR_SUB_LAST);
    wire last_bit = bit_tick && (bits_q == 4'h1);
    wire [3:0] frame_bits = cif.nine_bit ? `USDR_FRAME9 : `USDR_FRAME8;
    wire [3:0] brk_bits = (cif.long_brk ? `USDR_BRK_LONG : `USDR_BRK_SHORT) + {3'h0, cif.nine_bit};
    wire ninth_out = cif.nine_bit ? cif.tx_ninth : 1'b1;
    wire load = (st_q == usdr_pkg::usdr_tx_idle) && (cif.tx_brk || cif.tx_start);

    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bits_d = bits_q;
        unique case (st_q)
            usdr_pkg::usdr_tx_idle: begin
                if (cif.tx_brk) begin
                    sh_d = 11'h000;
                    bits_d = brk_bits;
                    st_d = usdr_pkg::usdr_tx_busy;
                end else if (cif.tx_start) begin
                    sh_d = {1'b1, ninth_out, cif.tx_data, 1'b0};
                    bits_d = frame_bits;
                    st_d = usdr_pkg::usdr_tx_busy;
                end
            end
            usdr_pkg::usdr_tx_busy: begin
                if (bit_tick) begin
                    // top bit refills: stop level after a frame, zero through a break
                    sh_d = {sh_q[10], sh_q[10:1]};
                    bits_d = bits_q - 4'h1;
                    if (last_bit) begin
                        st_d = usdr_pkg::usdr_tx_idle;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= usdr_pkg::usdr_tx_idle;
            sh_q <= 11'h7ff;
            bits_q <= 4'h0;
            sub_q <= 4'h0;
            done_q <= 1'b0;
        end else if (cif.ce) begin
            st_q <= st_d;
            sh_q <= sh_d;
            bits_q <= bits_d;
            sub_q <= load ? 4'h0 : (cif.tick16 ? sub_q + 4'h1 : sub_q);
            done_q <= last_bit;
        end
    end

    assign cif.tx_busy = (st_q == usdr_pkg::usdr_tx_busy);
    assign cif.tx_done = done_q;
    assign cif.tx_line = (st_q == usdr_pkg::usdr_tx_idle) ? 1'b1 : sh_q[0];

    a_brk_length: assert property (@(posedge clock) disable iff (!rst_b)
        cif.ce && load && cif.tx_brk |=> bits_q == $past(brk_bits))
        else $error("break length loaded wrong");
endmodule : usdr_tx
`default_nettype wire

// [verilog/usdr_rx.sv]
// receiver: 16x sampled start search, framing check, idle detection
`timescale 1ns/1ps
`default_nettype none
`include "usdr_defs.svh"
module usdr_rx (
    input wire logic clock,
    input wire logic rst_b,
    usdr_core_if.rx cif
);
    usdr_pkg::usdr_rx_state_t st_q, st_d;
    logic [8:0] sh_q;
    logic [3:0] sub_q, bits_q;
    logic [7:0] ones_q;
    logic armed_q, active_q, done_q, idle_q, ferr_q, ninth_q;
    logic [7:0] data_q;

    wire first_slot = cif.tick16 && (st_q == usdr_pkg::usdr_rx_idle) && !cif.rx_line;
    wire sample = cif.tick16 && (st_q != usdr_pkg::usdr_rx_idle) && (sub_q == `USDR_SUB_MID);
    wire [7:0] idle_len = cif.nine_bit ? `USDR_IDLE9 : `USDR_IDLE8;
    wire idle_hit = cif.tick16 && cif.rx_line && armed_q && (ones_q == idle_len - 8'h01);
    wire stop_now = sample && (st_q == usdr_pkg::usdr_rx_stop);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            usdr_pkg::usdr_rx_idle: if (first_slot) st_d = usdr_pkg::usdr_rx_start;
            usdr_pkg::usdr_rx_start: if (sample) st_d = cif.rx_line ? usdr_pkg::usdr_rx_idle : usdr_pkg::usdr_rx_data;
            usdr_pkg::usdr_rx_data: if (sample && bits_q == 4'h1) st_d = usdr_pkg::usdr_rx_stop;
            usdr_pkg::usdr_rx_stop: if (sample) st_d = usdr_pkg::usdr_rx_idle;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= usdr_pkg::usdr_rx_idle;
            sh_q <= 9'h000;
            sub_q <= 4'h0;
            bits_q <= 4'h0;
            ones_q <= 8'h00;
            armed_q <= 1'b1;
            active_q <= 1'b0;
        end else if (cif.ce) begin
            st_q <= st_d;
            sub_q <= first_slot ? 4'h0 : (cif.tick16 ? sub_q + 4'h1 : sub_q);
            if (sample && st_q == usdr_pkg::usdr_rx_start) begin
                bits_q <= cif.nine_bit ? `USDR_DATA9 : `USDR_DATA8;
            end else if (sample && st_q == usdr_pkg::usdr_rx_data) begin
                bits_q <= bits_q - 4'h1;
                sh_q <= {cif.rx_line, sh_q[8:1]};
            end
            if (cif.tick16) begin
                ones_q <= (cif.rx_line && !idle_hit) ? ones_q + 8'h01 : 8'h00;
            end
            armed_q <= idle_hit ? 1'b0 : (armed_q || stop_now);
            if (first_slot) begin
                active_q <= 1'b1;
            end else if (idle_hit) begin
                active_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
            idle_q <= 1'b0;
            ferr_q <= 1'b0;
            ninth_q <= 1'b0;
            data_q <= `USDR_RST_BYTE;
        end else if (cif.ce) begin
            done_q <= stop_now;
            idle_q <= idle_hit;
            ferr_q <= stop_now && !cif.rx_line;
            if (stop_now) begin
                data_q <= cif.nine_bit ? sh_q[7:0] : sh_q[8:1];
                ninth_q <= cif.nine_bit ? sh_q[8] : 1'b0;
            end
        end
    end

    assign cif.rx_done = done_q;
    assign cif.rx_idle = idle_q;
    assign cif.rx_ferr = ferr_q;
    assign cif.rx_ninth = ninth_q;
    assign cif.rx_data = data_q;
    assign cif.rx_active = active_q;
endmodule : usdr_rx
`default_nettype wire

// [verification/usdr_remote.sv]
// remote serial device on the transmit and receive lines
`timescale 1ns/1ps
`default_nettype none
module usdr_remote #(parameter int BIT_CLKS = 64) (
    input wire logic clock,
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;
    // start low, lsb first, stop high, then idle high
    task automatic send(input logic [8:0] d, input logic nine);
        line_out <= 1'b0;
        repeat (BIT_CLKS) @(posedge clock);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            line_out <= d[i];
            repeat (BIT_CLKS) @(posedge clock);
        end
        line_out <= 1'b1;
        repeat (BIT_CLKS) @(posedge clock);
    endtask : send
    task automatic recv(input logic nine, output logic [8:0] d);
        d = 9'h000;
        @(negedge line_in);
        repeat (BIT_CLKS / 2) @(posedge clock);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (BIT_CLKS) @(posedge clock);
            d[i] = line_in;
        end
        repeat (BIT_CLKS) @(posedge clock);
    endtask : recv
endmodule : usdr_remote
`default_nettype wire

// [verification/test_usdr_top.sv]
// self-checking bench for the serial port register slice
`timescale 1ns/1ps
`default_nettype none
module test_usdr_top;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d;} usdr_row_t;
    usdr_row_t rows [12] = '{'{1'b0, 4'h1, 8'h04}, '{1'b1, 4'h5, 8'hff}, '{1'b0, 4'h5, 8'h9e},
        '{1'b0, 4'h1, 8'h00}, '{1'b1, 4'h1, 8'h5a}, '{1'b0, 4'h1, 8'h5a}, '{1'b1, 4'h5, 8'h00},
        '{1'b0, 4'h1, 8'h04}, '{1'b1, 4'h6, 8'hff}, '{1'b0, 4'h6, 8'h40}, '{1'b1, 4'h9, 8'hff},
        '{1'b0, 4'h9, 8'h00}};
    logic clock = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, ce = 1'b1, special_mode = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    logic rxd_pin, txd_pin_out, txd_pin_oe, irq;
    wire logic txd_pin_in = txd_pin_oe ? txd_pin_out : 1'b1;
    int mismatches = 0, n_compared = 0, len;
    logic [8:0] got;
    always #25 clock = ~clock;
    usdr_top i_usdr_top (.clock(clock), .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .special_mode(special_mode), .rxd_pin(rxd_pin),
        .txd_pin_in(txd_pin_in), .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe), .irq(irq));
    usdr_remote i_usdr_remote (.clock(clock), .line_in(txd_pin_out), .line_out(rxd_pin));
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, rd_data});
    endtask : rd
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial begin
        #1_000_000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        rd(4'h5, 8'h00);
        rd(4'h7, 8'h00);
        foreach (rows[i]) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            else
                rd(rows[i].a, rows[i].d);
        end
        $display("register table done");
        wr(4'h3, 8'h0c);
        fork
            i_usdr_remote.send(9'h096, 1'b0);
            begin
                wr(4'h7, 8'ha5);
                repeat (200) @(posedge clock);
                rd(4'h5, 8'h01);
            end
            begin
                i_usdr_remote.recv(1'b0, got);
                chk("tx frame", 9'h0a5, got);
            end
        join
        repeat (800) @(posedge clock);
        rd(4'h5, 8'h00);
        rd(4'h7, 8'h96);
        rd(4'h4, 8'hb0);
        chk("irq masked", 9'h000, {8'h00, irq});
        wr(4'h8, 8'h20);
        repeat (2) @(posedge clock);
        chk("irq raised", 9'h001, {8'h00, irq});
        wr(4'h4, 8'h20);
        repeat (2) @(posedge clock);
        chk("irq cleared", 9'h000, {8'h00, irq});
        $display("duplex and interrupt done");
        wr(4'h2, 8'h10);
        wr(4'h6, 8'h40);
        for (int k = 0; k < 2; k++) begin
            fork
                wr(4'h7, k ? 8'hc3 : 8'h3c);
                i_usdr_remote.recv(1'b1, got);
            join
            chk("tx nine", k ? 9'h1c3 : 9'h13c, got);
        end
        i_usdr_remote.send(9'h15a, 1'b1);
        repeat (4) @(posedge clock);
        rd(4'h7, 8'h5a);
        rd(4'h6, 8'hc0);
        $display("nine bit done");
        wr(4'h5, 8'h04);
        wr(4'h3, 8'h0d);
        @(negedge txd_pin_out);
        len = 0;
        while (txd_pin_out === 1'b0 && len < 2000) begin
            @(posedge clock);
            len++;
        end
        chk("break bits", 9'd14, 9'((len + 32) / 64));
        wr(4'h5, 8'h10);
        repeat (3) @(posedge clock);
        chk("tx idle level", 9'h000, {8'h00, txd_pin_out});
        wr(4'h2, 8'ha0);
        wr(4'h5, 8'h00);
        repeat (3) @(posedge clock);
        chk("pin enable", 9'h000, {8'h00, txd_pin_oe});
        wr(4'h5, 8'h02);
        repeat (3) @(posedge clock);
        chk("pin enable", 9'h001, {8'h00, txd_pin_oe});
        $display("break and pin done");
        special_mode <= 1'b1;
        wr(4'h6, 8'h41);
        rd(4'h6, 8'hc1);
        wr(4'h6, 8'h40);
        rd(4'h6, 8'hc0);
        @(posedge clock);
        special_mode <= 1'b0;
        ce <= 1'b0;
        wr(4'h8, 8'hff);
        ce <= 1'b1;
        rd(4'h8, 8'h20);
        $display("test bits and enable done");
        wrap_up();
    end
endmodule : test_usdr_top
`default_nettype wire
